// File: verilog/dso_defs.vh
// register map, reset values and codes of the drive stop option block
`ifndef DSO_DEFS_VH
`define DSO_DEFS_VH
// object indexes and subentries; byte address = 4 * index
`define DSO_IDX_SCALE 16'h604c
`define DSO_IDX_QSTOP 16'h605a
`define DSO_IDX_SHUT 16'h605b
`define DSO_IDX_DIS 16'h605c
`define DSO_IDX_CTRL 16'h6070
`define DSO_IDX_STAT 16'h6071
`define DSO_IDX_QRAMP 16'h6072
`define DSO_IDX_SPEED 16'h6073
`define DSO_IDX_RPM 16'h6074
`define DSO_SUB_COUNT 2'h0
`define DSO_SUB_NUM 2'h1
`define DSO_SUB_DEN 2'h2
// byte address bits: [17:2] index, [19:18] subentry
`define DSO_ADR_IDX_LSB 2
`define DSO_ADR_SUB_LSB 18
// reset values
`define DSO_RST_COUNT 8'h02
`define DSO_RST_NUM 32'h00000001
`define DSO_RST_DEN 32'h00000001
`define DSO_RST_QSTOP 16'h0002
`define DSO_RST_SHUT 16'h0001
`define DSO_RST_DIS 16'h0001
`define DSO_RST_QR_SPEED 32'h00001388
`define DSO_RST_QR_TIME 16'h0001
// power states
`define DSO_PS_SOD 3'h0
`define DSO_PS_RTSO 3'h1
`define DSO_PS_SWON 3'h2
`define DSO_PS_OPEN 3'h3
`define DSO_PS_QSA 3'h4
// braking actions
`define DSO_ACT_NONE 3'h0
`define DSO_ACT_FREE 3'h1
`define DSO_ACT_IMM 3'h2
`define DSO_ACT_SLOW 3'h3
`define DSO_ACT_QUICK 3'h4
// control register bits
`define DSO_CTL_QSTOP 0
`define DSO_CTL_SHUT 1
`define DSO_CTL_DIS 2
`define DSO_CTL_ENABLE 3
`endif

// File: verilog/dso_top.v
// drive stop option objects, speed scaling and power state action logic
//
// Overview of operation
// [R1] speed scaled by signed numerator over denominator
// [R2] entry count two, numerator signed, reset one
// [R3] denominator signed 32-bit, reset one
// [R4] quick stop code signed 16-bit, reset two
// [R5] quick stop action applied entering quick stop
// [R6] code 0: immediate stop, then switch-on disabled
// [R7] codes 1/2: slow/quick ramp, then disabled
// [R8] code 5: slow ramp, stay quick stop active
// [R9] code 6: quick ramp, stay quick stop active
// [R10] shutdown code, reset one, on enabled-to-ready
// [R11] shutdown 0 free, 1 slow ramp then ready
// [R12] disable code, reset one, on enabled-to-switched-on
// [R13] disable 0 free, 1 slow ramp then switched-on
// [R14] quick stop ramp speed over time fraction
// [R15] reserved option code writes are ignored
//
// Our own choice: register access over Wishbone.
`include "dso_defs.vh"

module dso_top (
    input wire clk_i, // system clock 25 MHz
    input wire rst_i, // synchronous reset, active high
    input wire cyc_i, // wishbone cycle
    input wire stb_i, // wishbone strobe
    input wire we_i, // wishbone write enable
    input wire [19:0] adr_i, // wishbone byte address
    input wire [3:0] sel_i, // wishbone byte selects
    input wire [31:0] dat_i, // wishbone write data
    output reg [31:0] dat_o, // wishbone read data
    output reg ack_o, // wishbone acknowledge
    input wire [31:0] speed_int_i, // internal signed speed value
    input wire standstill_i, // motor has reached standstill
    output reg [31:0] speed_rpm_o, // scaled signed speed
    output reg [2:0] power_state_o, // current power state
    output reg [2:0] brake_action_o, // active braking action
    output reg energized_o // motor power stage on
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [31:0] num_reg;
reg [31:0] den_reg;
reg [15:0] qstop_reg;
reg [15:0] shut_reg;
reg [15:0] dis_reg;
reg [31:0] qr_speed_reg;
reg [15:0] qr_time_reg;
reg [3:0] ctrl_reg;
reg [2:0] ps_reg;
reg [2:0] act_reg;
reg [2:0] after_reg;
reg [31:0] rpm_reg;

// object index and subentry fields of the bus address
wire [15:0] idx = adr_i[`DSO_ADR_IDX_LSB+15:`DSO_ADR_IDX_LSB];
wire [1:0] sub = adr_i[`DSO_ADR_SUB_LSB+1:`DSO_ADR_SUB_LSB];
wire req = cyc_i & stb_i & ~ack_o;
wire wr = req & we_i;

// merge write data into an old word by byte selects
function [31:0] bmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer i;
    begin
        bmerge = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
                bmerge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    end
endfunction

// true when a 16-bit option code is one that the object defines
function code_ok;
    input [15:0] code;
    input [1:0] kind; // 0 quick stop, 1 shutdown/disable
    begin
        if (kind == 2'h0) begin
            code_ok = (code == 16'h0000) | (code == 16'h0001) |
                (code == 16'h0002) | (code == 16'h0005) |
                (code == 16'h0006);
        end else begin
            code_ok = (code == 16'h0000) | (code == 16'h0001);
        end
    end
endfunction

// option code words as they would stand after a byte-merged write
wire [31:0] wqs = bmerge({16'h0000, qstop_reg}, dat_i, sel_i);
wire [31:0] wsh = bmerge({16'h0000, shut_reg}, dat_i, sel_i);
wire [31:0] wds = bmerge({16'h0000, dis_reg}, dat_i, sel_i);

// ----------------------------------------------------------------
// wishbone slave: one wait-free ack cycle, unmapped reads zero
// ----------------------------------------------------------------
always @(posedge clk_i) begin
    if (rst_i) begin
        ack_o <= 1'b0;
        dat_o <= 32'h00000000;
        num_reg <= `DSO_RST_NUM; // [R2]
        den_reg <= `DSO_RST_DEN; // [R3]
        qstop_reg <= `DSO_RST_QSTOP; // [R4]
        shut_reg <= `DSO_RST_SHUT; // [R10]
        dis_reg <= `DSO_RST_DIS; // [R12]
        qr_speed_reg <= `DSO_RST_QR_SPEED;
        qr_time_reg <= `DSO_RST_QR_TIME;
        ctrl_reg <= 4'h0;
    end else begin
        ack_o <= req;
        dat_o <= 32'h00000000;
        if (req & ~we_i) begin
            case (idx)
                `DSO_IDX_SCALE: begin
                    case (sub)
                        `DSO_SUB_COUNT: dat_o <= {24'h000000,
                            `DSO_RST_COUNT}; // [R2]
                        `DSO_SUB_NUM: dat_o <= num_reg;
                        `DSO_SUB_DEN: dat_o <= den_reg;
                        default: dat_o <= 32'h00000000;
                    endcase
                end
                `DSO_IDX_QSTOP: dat_o <= {{16{qstop_reg[15]}}, qstop_reg};
                `DSO_IDX_SHUT: dat_o <= {{16{shut_reg[15]}}, shut_reg};
                `DSO_IDX_DIS: dat_o <= {{16{dis_reg[15]}}, dis_reg};
                `DSO_IDX_CTRL: dat_o <= {28'h0000000, ctrl_reg};
                // status word: power stage, action, state
                `DSO_IDX_STAT: dat_o <= {25'h0000000, energized_o,
                    brake_action_o, power_state_o};
                `DSO_IDX_QRAMP: dat_o <= (sub == `DSO_SUB_NUM) ?
                    qr_speed_reg : {16'h0000, qr_time_reg};
                `DSO_IDX_SPEED: dat_o <= speed_int_i;
                `DSO_IDX_RPM: dat_o <= rpm_reg;
                default: dat_o <= 32'h00000000;
            endcase
        end
        if (wr) begin
            case (idx)
                `DSO_IDX_SCALE: begin
                    if (sub == `DSO_SUB_NUM) begin
                        num_reg <= bmerge(num_reg, dat_i, sel_i); // [R2]
                    end
                    if (sub == `DSO_SUB_DEN) begin
                        den_reg <= bmerge(den_reg, dat_i, sel_i); // [R3]
                    end
                end
                `DSO_IDX_QSTOP: if (code_ok(wqs[15:0], 2'h0)) begin
                    qstop_reg <= wqs[15:0]; // [R15]
                end
                `DSO_IDX_SHUT: if (code_ok(wsh[15:0], 2'h1)) begin
                    shut_reg <= wsh[15:0]; // [R15]
                end
                `DSO_IDX_DIS: if (code_ok(wds[15:0], 2'h1)) begin
                    dis_reg <= wds[15:0]; // [R15]
                end
                `DSO_IDX_CTRL: ctrl_reg <= dat_i[3:0];
                `DSO_IDX_QRAMP: begin
                    if (sub == `DSO_SUB_NUM) begin
                        qr_speed_reg <= bmerge(qr_speed_reg, dat_i,
                            sel_i); // [R14]
                    end
                    if (sub == `DSO_SUB_DEN) begin
                        qr_time_reg <= dat_i[15:0]; // [R14]
                    end
                end
                default: ;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// speed scaling: rpm = speed * num / den, den of zero holds value
// ----------------------------------------------------------------
// full-width product keeps the sign ahead of the divide
wire signed [63:0] prod = $signed(speed_int_i) * $signed(num_reg);
wire signed [63:0] quot = prod / $signed({{32{den_reg[31]}}, den_reg});

always @(posedge clk_i) begin
    if (rst_i) begin
        rpm_reg <= 32'h00000000;
    end else if (den_reg != 32'h00000000) begin
        rpm_reg <= quot[31:0]; // [R1]
    end
end

// ----------------------------------------------------------------
// power state machine with option code actions
// ----------------------------------------------------------------
// next state, braking action and state taken when braking ends
reg [2:0] ps_next;
reg [2:0] act_next;
reg [2:0] after_next;

always @* begin
    ps_next = ps_reg;
    act_next = act_reg;
    after_next = after_reg;
    if (act_reg != `DSO_ACT_NONE) begin
        // braking in progress: ramps finish at standstill, free and immediate stops at once
        if (standstill_i | act_reg == `DSO_ACT_FREE |
                act_reg == `DSO_ACT_IMM) begin
            act_next = `DSO_ACT_NONE;
            ps_next = after_reg;
        end
    end else begin
        case (ps_reg)
            `DSO_PS_SOD: if (ctrl_reg[`DSO_CTL_SHUT])
                ps_next = `DSO_PS_RTSO;
            `DSO_PS_RTSO: if (ctrl_reg[`DSO_CTL_DIS])
                ps_next = `DSO_PS_SWON;
            `DSO_PS_SWON: if (ctrl_reg[`DSO_CTL_ENABLE])
                ps_next = `DSO_PS_OPEN;
            `DSO_PS_OPEN: begin
                if (ctrl_reg[`DSO_CTL_QSTOP]) begin
                    ps_next = `DSO_PS_QSA; // [R5]
                    case (qstop_reg)
                        16'h0000: begin
                            act_next = `DSO_ACT_IMM; // [R6]
                            after_next = `DSO_PS_SOD;
                        end
                        16'h0001: begin
                            act_next = `DSO_ACT_SLOW; // [R7]
                            after_next = `DSO_PS_SOD;
                        end
                        16'h0005: begin
                            act_next = `DSO_ACT_SLOW; // [R8]
                            after_next = `DSO_PS_QSA;
                        end
                        16'h0006: begin
                            act_next = `DSO_ACT_QUICK; // [R9]
                            after_next = `DSO_PS_QSA;
                        end
                        default: begin
                            act_next = `DSO_ACT_QUICK; // [R7]
                            after_next = `DSO_PS_SOD;
                        end
                    endcase
                end else if (!ctrl_reg[`DSO_CTL_SHUT]) begin
                    ps_next = `DSO_PS_RTSO; // [R10]
                    after_next = `DSO_PS_RTSO;
                    act_next = (shut_reg == 16'h0000) ? `DSO_ACT_FREE :
                        `DSO_ACT_SLOW; // [R11]
                end else if (!ctrl_reg[`DSO_CTL_ENABLE]) begin
                    ps_next = `DSO_PS_SWON; // [R12]
                    after_next = `DSO_PS_SWON;
                    act_next = (dis_reg == 16'h0000) ? `DSO_ACT_FREE :
                        `DSO_ACT_SLOW; // [R13]
                end
            end
            `DSO_PS_QSA: begin
                // codes 5 and 6 may return to operation enabled
                if (!ctrl_reg[`DSO_CTL_QSTOP] &
                        ctrl_reg[`DSO_CTL_ENABLE]) begin
                    ps_next = `DSO_PS_OPEN; // [R8] [R9]
                end else if (!ctrl_reg[`DSO_CTL_SHUT]) begin
                    ps_next = `DSO_PS_SOD;
                end
            end
            default: ps_next = `DSO_PS_SOD;
        endcase
        // dropping shutdown from lower states returns to disabled
        if (ps_reg != `DSO_PS_OPEN & ps_reg != `DSO_PS_QSA &
                ps_reg != `DSO_PS_SOD & !ctrl_reg[`DSO_CTL_SHUT]) begin
            ps_next = `DSO_PS_SOD;
        end
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        ps_reg <= `DSO_PS_SOD;
        act_reg <= `DSO_ACT_NONE;
        after_reg <= `DSO_PS_SOD;
    end else begin
        ps_reg <= ps_next;
        act_reg <= act_next;
        after_reg <= after_next;
    end
end

// registered outputs
always @(posedge clk_i) begin
    if (rst_i) begin
        speed_rpm_o <= 32'h00000000;
        power_state_o <= `DSO_PS_SOD;
        brake_action_o <= `DSO_ACT_NONE;
        energized_o <= 1'b0;
    end else begin
        speed_rpm_o <= rpm_reg;
        power_state_o <= ps_next;
        brake_action_o <= act_next;
        energized_o <= (ps_next == `DSO_PS_OPEN | ps_next == `DSO_PS_QSA)
            & act_next != `DSO_ACT_FREE & act_next != `DSO_ACT_IMM;
    end
end

endmodule // dso_top

// File: verification/dso_top_sva.sv
// port checker of the drive stop option block
`include "dso_defs.vh"
module dso_top_chk (
    input wire clk_i, // system clock
    input wire rst_i, // synchronous reset
    input wire cyc_i, // bus cycle
    input wire stb_i, // bus strobe
    input wire ack_o, // bus acknowledge
    input wire [2:0] power_state_o, // power state
    input wire [2:0] brake_action_o, // braking action
    input wire energized_o // power stage on
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // --------------------------------------------------
    // bus handshake
    // --------------------------------------------------
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acked next cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    // --------------------------------------------------
    // power state actions
    // --------------------------------------------------
    qs_entry_a: assert property ($changed(power_state_o) &&
        power_state_o == `DSO_PS_QSA |-> $past(power_state_o) == `DSO_PS_OPEN)
        else $error("quick stop entered from wrong state");
    qs_brake_a: assert property ($changed(power_state_o) &&
        power_state_o == `DSO_PS_QSA |-> ##[0:2] brake_action_o inside
        {`DSO_ACT_IMM, `DSO_ACT_SLOW, `DSO_ACT_QUICK})
        else $error("quick stop without braking action");
    qs_exit_a: assert property ($changed(power_state_o) &&
        $past(power_state_o) == `DSO_PS_QSA |->
        power_state_o inside {`DSO_PS_SOD, `DSO_PS_OPEN})
        else $error("quick stop left to wrong state");
    open_exit_a: assert property ($changed(power_state_o) &&
        $past(power_state_o) == `DSO_PS_OPEN |-> power_state_o inside
        {`DSO_PS_QSA, `DSO_PS_RTSO, `DSO_PS_SWON})
        else $error("enabled state left to wrong state");
    qs_hold_a: assert property (power_state_o == `DSO_PS_QSA &&
        brake_action_o == `DSO_ACT_NONE |-> energized_o)
        else $error("quick stop hold not energized");
    cover property (power_state_o == `DSO_PS_QSA ##1
        power_state_o == `DSO_PS_SOD);
    cover property (brake_action_o == `DSO_ACT_FREE);
    cover property (power_state_o == `DSO_PS_QSA && energized_o);
endmodule // dso_top_chk

bind dso_top dso_top_chk chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .power_state_o(power_state_o),
    .brake_action_o(brake_action_o), .energized_o(energized_o));

// File: verification/dso_motor_model.sv
// behavioural motor that reaches standstill after braking
`include "dso_defs.vh"
module dso_motor_model (
    input wire logic clk_i, // system clock
    input wire logic [7:0] delay_i, // ramp length in cycles
    input wire logic [2:0] brake_action_i, // braking action
    input wire logic energized_i, // power stage on
    output logic standstill_o // motor stopped
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_reg = 0;
    wire ramp = brake_action_i inside {`DSO_ACT_SLOW, `DSO_ACT_QUICK};
    // ramp length counter, prompt or slow as the bench asks
    always @(posedge clk_i) cnt_reg <= ramp ? cnt_reg + 8'h01 : 8'h00;
    // a running motor turns unless braked down or unpowered
    assign standstill_o = ramp ? cnt_reg >= delay_i : !energized_i;
endmodule // dso_motor_model

// File: verification/drive_stop_option_config_test.sv
// self-checking bench of the drive stop option block
`include "dso_defs.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
fail_count++; $display("BAD %0t mismatch", $time); end end
module drive_stop_option_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [19:0] adr_i = 0;
    logic [31:0] dat_i = 0, speed_int_i = 0, dat_o, speed_rpm_o, q;
    logic [2:0] power_state_o, brake_action_o, a, s;
    logic ack_o, energized_o, standstill_i;
    logic [7:0] slow = 0;
    int fail_count = 0, num_checks = 0, cycles = 0, i, k;
    logic [15:0] qc[5] = '{0, 1, 2, 5, 6};
    always #20 clk_i = ~clk_i;
    dso_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .speed_int_i(speed_int_i),
        .standstill_i(standstill_i), .speed_rpm_o(speed_rpm_o),
        .power_state_o(power_state_o), .brake_action_o(brake_action_o),
        .energized_o(energized_o));
    dso_motor_model motor (.clk_i(clk_i), .delay_i(slow),
        .brake_action_i(brake_action_o), .energized_i(energized_o),
        .standstill_o(standstill_i));
    task final_report();
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end
    function automatic [19:0] oa(input [15:0] idx, input [1:0] sub);
        oa = {sub, idx, 2'b00};
    endfunction
    // one classic bus cycle, idle cycle before it
    task wb(input logic w, input logic [19:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= ad; dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 0; stb_i <= 0;
    endtask
    task rd(input logic [19:0] ad, input logic [31:0] e);
        wb(0, ad, 0);
        `CHK(q, e)
    endtask
    task ctl(input logic [31:0] v);
        wb(1, oa(`DSO_IDX_CTRL, 0), v);
    endtask
    // bounded wait for a state
    task wst(input logic [2:0] st);
        #1;
        for (i = 0; i < 40 && power_state_o !== st; i++)
            @(posedge clk_i) #1;
    endtask
    task go_open();
        ctl(0); wst(`DSO_PS_SOD); ctl(2); ctl(6); ctl(14);
        wst(`DSO_PS_OPEN);
        `CHK(power_state_o, `DSO_PS_OPEN)
    endtask
    // braking action seen, then final state
    task run(input logic [2:0] act, input logic [2:0] st);
        #1;
        for (i = 0; i < 20 && brake_action_o !== act; i++)
            @(posedge clk_i) #1;
        `CHK(brake_action_o, act)
        // braking ends, then the final state must stand
        for (i = 0; i < 40 && brake_action_o !== `DSO_ACT_NONE; i++)
            @(posedge clk_i) #1;
        `CHK(brake_action_o, `DSO_ACT_NONE)
        `CHK(power_state_o, st)
        wst(st);
        `CHK(power_state_o, st)
        `CHK(energized_o, st == `DSO_PS_QSA)
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        rd(oa(`DSO_IDX_SCALE, 0), 2);
        rd(oa(`DSO_IDX_SCALE, 1), 1);
        rd(oa(`DSO_IDX_SCALE, 2), 1);
        rd(oa(`DSO_IDX_QSTOP, 0), 2);
        rd(oa(`DSO_IDX_SHUT, 0), 1);
        rd(oa(`DSO_IDX_DIS, 0), 1);
        rd(oa(`DSO_IDX_STAT, 0), 0);
        rd(oa(`DSO_IDX_QRAMP, 1), `DSO_RST_QR_SPEED);
        rd(oa(`DSO_IDX_QRAMP, 2), `DSO_RST_QR_TIME);
        wb(1, oa(`DSO_IDX_SCALE, 0), 5);
        rd(oa(`DSO_IDX_SCALE, 0), 2);
        wb(1, oa(16'h1000, 0), 7);
        rd(oa(16'h1000, 0), 0);
        speed_int_i <= 7;
        wb(1, oa(`DSO_IDX_SCALE, 1), 60);
        rd(oa(`DSO_IDX_RPM, 0), 420);
        wb(1, oa(`DSO_IDX_SCALE, 1), 3);
        rd(oa(`DSO_IDX_SCALE, 1), 3);
        wb(1, oa(`DSO_IDX_SCALE, 2), -2);
        speed_int_i <= 5;
        rd(oa(`DSO_IDX_SCALE, 2), -2);
        `CHK(speed_rpm_o, -7)
        rd(oa(`DSO_IDX_SPEED, 0), 5);
        wb(1, oa(`DSO_IDX_QSTOP, 0), 3);
        rd(oa(`DSO_IDX_QSTOP, 0), 2);
        wb(1, oa(`DSO_IDX_SHUT, 0), 2);
        rd(oa(`DSO_IDX_SHUT, 0), 1);
        wb(1, oa(`DSO_IDX_DIS, 0), -1);
        rd(oa(`DSO_IDX_DIS, 0), 1);
        for (k = 0; k < 5; k++) begin
            slow <= 8'(k * 3);
            a = k == 0 ? `DSO_ACT_IMM : k[0] ? `DSO_ACT_SLOW : `DSO_ACT_QUICK;
            s = k > 2 ? `DSO_PS_QSA : `DSO_PS_SOD;
            wb(1, oa(`DSO_IDX_QSTOP, 0), 32'(qc[k]));
            rd(oa(`DSO_IDX_QSTOP, 0), 32'(qc[k]));
            go_open();
            ctl(15);
            run(a, s);
            if (k > 2) begin
                ctl(14);
                wst(`DSO_PS_OPEN);
                `CHK(power_state_o, `DSO_PS_OPEN)
            end
        end
        for (k = 0; k < 2; k++) begin
            a = k ? `DSO_ACT_SLOW : `DSO_ACT_FREE;
            wb(1, oa(`DSO_IDX_SHUT, 0), k);
            go_open();
            ctl(12);
            run(a, `DSO_PS_RTSO);
            wb(1, oa(`DSO_IDX_DIS, 0), k);
            go_open();
            ctl(6);
            run(a, `DSO_PS_SWON);
        end
        final_report();
    end
endmodule // drive_stop_option_config_test
